// ===== rtl/lsld_pkg.sv
package lsld_pkg;

  // Clock rate and blink timing
  localparam int CLK_KHZ = 10000;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int BLINK_CNT_W = 20;

  // Register locations mirrored by the mode and strap ports
  localparam logic [4:0] VENDOR_CTRL_ADDR = 5'h1e;
  localparam int MODE_FIELD_MSB = 15;
  localparam int MODE_FIELD_LSB = 14;
  localparam logic [4:0] BASIC_CTRL_ADDR = 5'h00;
  localparam int SPEED_SEL_BIT = 13;
  localparam logic [4:0] AN_ADV_ADDR = 5'h04;

  // Indicator modes; the upper two encodings are reserved
  localparam logic [1:0] MODE_LINK_ACT = 2'h0;
  localparam logic [1:0] MODE_LINK_ONLY = 2'h1;

  // Reset values
  localparam logic LAMP_OFF = 1'h1;
  localparam logic STRAP_SPEED_RST = 1'h1;
  localparam logic STRAP_AN_RST = 1'h1;
  localparam logic [1:0] PIN_SYNC_RST = 2'h3;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

  typedef enum logic {
    LSLD_ST_STRAP,
    LSLD_ST_DRIVE
  } lsld_pin_state_t;

endpackage

// ===== rtl/lsld_blink.sv
`timescale 1ns/100ps

// Half-period counter for the activity blink; phase restarts when activity stops
module lsld_blink #(
  parameter int HALF_CYC = lsld_pkg::BLINK_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic active_i,
  output logic phase_o
);

  localparam logic [lsld_pkg::BLINK_CNT_W-1:0] LAST =
    lsld_pkg::BLINK_CNT_W'(HALF_CYC - 1);

  logic [lsld_pkg::BLINK_CNT_W-1:0] count;

  // Counter runs only while traffic is seen
  always_ff @(posedge mclk_i) begin
    if (rst_i || !active_i) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // Phase flips once per half period, giving a slow visible blink
  always_ff @(posedge mclk_i) begin
    if (rst_i || !active_i) begin
      phase_o <= 1'b0;
    end else if (count == LAST) begin // RQ12
      phase_o <= ~phase_o;
    end
  end

endmodule // lsld_blink

// ===== rtl/lsld_top.sv
`timescale 1ns/100ps

// Operation
// RQ1 - Both lamp behaviours are chosen by the two-bit mode field of the vendor control register.
// RQ2 - Mode 00: lamp A is high without link, low with link, and toggles during activity.
// RQ3 - Mode 01: lamp A is high without link and low with link, never blinking.
// RQ4 - Mode 00: lamp B is high at 10 Mbps and low at 100 Mbps.
// RQ5 - Mode 01: lamp B is high without activity and toggles during activity.
// RQ6 - Software keeps the reserved mode values 10 and 11 out of the mode field.
// RQ7 - The chip reset pin is active low and resets the lamp logic and the strap capture.
// RQ8 - Each lamp pin is an input during reset so its strap can be read, and an output after.
// RQ9 - The lamp B pin level seen during reset becomes the speed select of control register 0h.
// RQ10 - That speed strap feeds bit 13 of register 0h and the advertised speed of register 4h.
// RQ11 - A high speed strap, the pull-up default, means 100 Mbps and a low one 10 Mbps.
// RQ12 - Activity is transmit or receive traffic, shown by a fixed slow blink.
module lsld_top #(
  parameter int BLINK_HALF_CYC = lsld_pkg::BLINK_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic chip_rst_n_i,
  input wire logic [1:0] lamp_mode_i,
  input wire logic link_up_i,
  input wire logic hundred_mbps_link_i,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic status_lamp_a_i,
  input wire logic status_lamp_b_i,
  output logic status_lamp_a_o,
  output logic status_lamp_a_oe_o,
  output logic status_lamp_b_o,
  output logic status_lamp_b_oe_o,
  output logic speed_sel_o,
  output logic adv_speed_o,
  output logic autoneg_strap_o
);

  logic [1:0] rst_n_sync;
  logic [1:0] lamp_a_sync;
  logic [1:0] lamp_b_sync;
  logic chip_rst;
  logic in_reset;
  lsld_pkg::lsld_pin_state_t pin_state;
  logic strap_speed;
  logic strap_an;
  logic activity;
  logic blink_phase;
  logic next_lamp_a;
  logic next_lamp_b;

  // The chip reset pin is asynchronous to mclk, so it is brought in by two flops
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rst_n_sync <= lsld_pkg::RST_SYNC_RST;
    end else begin
      rst_n_sync <= {rst_n_sync[0], chip_rst_n_i};
    end
  end

  // Low level on the pin means reset
  assign chip_rst = ~rst_n_sync[1]; // RQ7
  assign in_reset = srst_i | chip_rst; // RQ7

  // Lamp A strap level comes from a board resistor, outside the clock domain
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lamp_a_sync <= lsld_pkg::PIN_SYNC_RST;
    end else begin
      lamp_a_sync <= {lamp_a_sync[0], status_lamp_a_i};
    end
  end

  // Lamp B strap level, same two-flop path; only the second flop is read
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lamp_b_sync <= lsld_pkg::PIN_SYNC_RST;
    end else begin
      lamp_b_sync <= {lamp_b_sync[0], status_lamp_b_i};
    end
  end

  // Pins listen while any reset is active and start driving once it ends
  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      pin_state <= lsld_pkg::LSLD_ST_STRAP; // RQ8
    end else begin
      case (pin_state)
        lsld_pkg::LSLD_ST_STRAP: pin_state <= lsld_pkg::LSLD_ST_DRIVE; // RQ8
        lsld_pkg::LSLD_ST_DRIVE: pin_state <= lsld_pkg::LSLD_ST_DRIVE;
        default: pin_state <= lsld_pkg::LSLD_ST_STRAP;
      endcase
    end
  end

  // Speed strap: follow the lamp B pin during chip reset, freeze at release.
  // The local srst only restores the pull-up default, since the pin
  // synchronisers are themselves held then and carry no real level.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      strap_speed <= lsld_pkg::STRAP_SPEED_RST; // RQ11
    end else if (chip_rst) begin
      strap_speed <= lamp_b_sync[1]; // RQ9
    end
  end

  // Auto-negotiation strap: same capture window, taken from the lamp A pin
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      strap_an <= lsld_pkg::STRAP_AN_RST;
    end else if (chip_rst) begin
      strap_an <= lamp_a_sync[1];
    end
  end

  // Speed select bit of the basic control register: high means 100 Mbps
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      speed_sel_o <= lsld_pkg::STRAP_SPEED_RST;
    end else begin
      speed_sel_o <= strap_speed; // RQ10
    end
  end

  // Advertised speed mirrors the same strap, so both registers always agree
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      adv_speed_o <= lsld_pkg::STRAP_SPEED_RST;
    end else begin
      adv_speed_o <= strap_speed; // RQ10
    end
  end

  // Auto-negotiation enable as captured from the lamp A pin
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      autoneg_strap_o <= lsld_pkg::STRAP_AN_RST;
    end else begin
      autoneg_strap_o <= strap_an;
    end
  end

  // Either direction of traffic counts as activity
  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      activity <= 1'b0;
    end else begin
      activity <= tx_active_i | rx_active_i; // RQ12
    end
  end

  // One blink generator serves both lamps; lamp A blinks in mode 00 and lamp B in mode 01
  lsld_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .mclk_i(mclk_i),
    .rst_i(in_reset),
    .active_i(activity),
    .phase_o(blink_phase)
  );

  // Lamp levels per mode; high is off. Reserved modes leave both lamps off.
  always_comb begin
    next_lamp_a = lsld_pkg::LAMP_OFF;
    next_lamp_b = lsld_pkg::LAMP_OFF;
    case (lamp_mode_i) // RQ1
      lsld_pkg::MODE_LINK_ACT: begin
        if (!link_up_i) begin
          next_lamp_a = lsld_pkg::LAMP_OFF; // RQ2
        end else if (activity) begin
          next_lamp_a = blink_phase; // RQ2
        end else begin
          next_lamp_a = ~lsld_pkg::LAMP_OFF; // RQ2
        end
        next_lamp_b = ~hundred_mbps_link_i; // RQ4
      end
      lsld_pkg::MODE_LINK_ONLY: begin
        next_lamp_a = ~link_up_i; // RQ3
        if (activity) begin
          next_lamp_b = blink_phase; // RQ5
        end else begin
          next_lamp_b = lsld_pkg::LAMP_OFF; // RQ5
        end
      end
      default: begin
        next_lamp_a = lsld_pkg::LAMP_OFF;
        next_lamp_b = lsld_pkg::LAMP_OFF;
      end
    endcase
  end

  // Lamp A level idles high like the pull-up, so enabling the pin causes no glitch
  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      status_lamp_a_o <= lsld_pkg::LAMP_OFF;
    end else begin
      status_lamp_a_o <= next_lamp_a;
    end
  end

  // Lamp B level, same idle level as lamp A
  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      status_lamp_b_o <= lsld_pkg::LAMP_OFF;
    end else begin
      status_lamp_b_o <= next_lamp_b;
    end
  end

  // Lamp A drive enable: low through reset so the strap level can be read
  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      status_lamp_a_oe_o <= 1'b0; // RQ8
    end else begin
      status_lamp_a_oe_o <= (pin_state == lsld_pkg::LSLD_ST_DRIVE); // RQ8
    end
  end

  // Lamp B drive enable: one edge after the level, once the strap is frozen
  always_ff @(posedge mclk_i) begin
    if (in_reset) begin
      status_lamp_b_oe_o <= 1'b0; // RQ8
    end else begin
      status_lamp_b_oe_o <= (pin_state == lsld_pkg::LSLD_ST_DRIVE); // RQ8
    end
  end

endmodule // lsld_top

// ===== tb/lsld_monitor.sv
`timescale 1ns/100ps
// Lamps lag mode, link and speed by one edge and traffic by two
module lsld_monitor #(
  parameter int BLINK_HALF_CYC = 4
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic chip_rst_n_i,
  input wire logic [1:0] lamp_mode_i,
  input wire logic link_up_i,
  input wire logic hundred_mbps_link_i,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic status_lamp_a_i,
  input wire logic status_lamp_b_i,
  input wire logic status_lamp_a_o,
  input wire logic status_lamp_a_oe_o,
  input wire logic status_lamp_b_o,
  input wire logic status_lamp_b_oe_o,
  input wire logic speed_sel_o,
  input wire logic adv_speed_o,
  input wire logic autoneg_strap_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  // Pins released and both lamps dark
  wire quiet = !status_lamp_a_oe_o && !status_lamp_b_oe_o && status_lamp_a_o && status_lamp_b_o;
  sequence s_busy;
    tx_active_i && lamp_mode_i == 2'h1 && status_lamp_b_oe_o;
  endsequence
  sequence s_strap;
    !chip_rst_n_i && !srst_i && $stable(status_lamp_a_i) && $stable(status_lamp_b_i);
  endsequence
  a_lamp_a_off: assert property (status_lamp_a_oe_o && !$past(lamp_mode_i[1])
    && !$past(link_up_i) |-> status_lamp_a_o) else $error("lamp a lit");
  a_lamp_a_steady: assert property (status_lamp_a_oe_o && $past(lamp_mode_i) == 2'h1
    |-> status_lamp_a_o == !$past(link_up_i)) else $error("lamp a link");
  a_lamp_b_speed: assert property (status_lamp_b_oe_o && $past(lamp_mode_i) == 2'h0
    |-> status_lamp_b_o == !$past(hundred_mbps_link_i)) else $error("lamp b speed");
  a_lamp_b_idle: assert property (status_lamp_b_oe_o && $past(lamp_mode_i) == 2'h1
    && !$past(tx_active_i, 2) && !$past(rx_active_i, 2) |-> status_lamp_b_o) else $error("b idle");
  a_blink_b: assert property (s_busy [*8] |->
    status_lamp_b_o != $past(status_lamp_b_o, BLINK_HALF_CYC)) else $error("b blink");
  a_srst_quiet: assert property ($fell(srst_i) |-> quiet) else $error("srst lamps");
  a_chip_quiet: assert property (!chip_rst_n_i [*4] |-> quiet) else $error("rst lamps");
  a_strap_load: assert property (s_strap [*6] |-> speed_sel_o == status_lamp_b_i
    && adv_speed_o == status_lamp_b_i && autoneg_strap_o == status_lamp_a_i) else $error("strap");
endmodule // lsld_monitor

bind lsld_top lsld_monitor #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) mon (.mclk_i(mclk_i),
  .srst_i(srst_i), .chip_rst_n_i(chip_rst_n_i), .lamp_mode_i(lamp_mode_i),
  .link_up_i(link_up_i), .hundred_mbps_link_i(hundred_mbps_link_i),
  .tx_active_i(tx_active_i), .rx_active_i(rx_active_i), .status_lamp_a_i(status_lamp_a_i),
  .status_lamp_b_i(status_lamp_b_i), .status_lamp_a_o(status_lamp_a_o),
  .status_lamp_a_oe_o(status_lamp_a_oe_o), .status_lamp_b_o(status_lamp_b_o),
  .status_lamp_b_oe_o(status_lamp_b_oe_o), .speed_sel_o(speed_sel_o),
  .adv_speed_o(adv_speed_o), .autoneg_strap_o(autoneg_strap_o));

// ===== tb/lsld_pins.sv
`timescale 1ns/100ps
// Board at the lamp pins; a released pin shows the resistor, never the last drive
module lsld_pins (
  input wire logic oe_a_i,
  input wire logic drv_a_i,
  input wire logic oe_b_i,
  input wire logic drv_b_i,
  input wire logic res_a_i,
  input wire logic res_b_i,
  output logic pin_a_o,
  output logic pin_b_o
);
  // Lamp drive wins while enabled
  assign pin_a_o = oe_a_i ? drv_a_i : res_a_i;
  assign pin_b_o = oe_b_i ? drv_b_i : res_b_i;
endmodule // lsld_pins

// ===== tb/lsld_top_tb.sv
`timescale 1ns/100ps
module lsld_top_tb;
  localparam int HALF = 4;
  logic mclk_i = 0, srst_i = 1, chip_rst_n_i = 0, link_up_i = 0, hundred_mbps_link_i = 0;
  logic tx_active_i = 0, rx_active_i = 0, sa = 1, sb = 1, status_lamp_a_i, status_lamp_b_i;
  logic status_lamp_a_o, status_lamp_a_oe_o, status_lamp_b_o, status_lamp_b_oe_o, p;
  logic speed_sel_o, adv_speed_o, autoneg_strap_o;
  logic [1:0] lamp_mode_i = 2'h0, e;
  int errors = 0, n_checks = 0, k, t;
  wire [1:0] lamp = {status_lamp_a_o, status_lamp_b_o};
  always #50 mclk_i = ~mclk_i;
  lsld_top #(.BLINK_HALF_CYC(HALF)) uut (.mclk_i(mclk_i), .srst_i(srst_i),
    .chip_rst_n_i(chip_rst_n_i), .lamp_mode_i(lamp_mode_i), .link_up_i(link_up_i),
    .hundred_mbps_link_i(hundred_mbps_link_i), .tx_active_i(tx_active_i),
    .rx_active_i(rx_active_i), .status_lamp_a_i(status_lamp_a_i),
    .status_lamp_b_i(status_lamp_b_i), .status_lamp_a_o(status_lamp_a_o),
    .status_lamp_a_oe_o(status_lamp_a_oe_o), .status_lamp_b_o(status_lamp_b_o),
    .status_lamp_b_oe_o(status_lamp_b_oe_o), .speed_sel_o(speed_sel_o),
    .adv_speed_o(adv_speed_o), .autoneg_strap_o(autoneg_strap_o));
  lsld_pins board (.oe_a_i(status_lamp_a_oe_o), .drv_a_i(status_lamp_a_o),
    .oe_b_i(status_lamp_b_oe_o), .drv_b_i(status_lamp_b_o), .res_a_i(sa), .res_b_i(sb),
    .pin_a_o(status_lamp_a_i), .pin_b_o(status_lamp_b_i));
  // Idle {lamp a, lamp b}; reserved modes leave both dark
  function automatic logic [1:0] lamps(logic [1:0] m, logic l, logic s);
    return m[1] ? 2'h3 : {~l, m[0] | ~s};
  endfunction
  // Inputs move 10 ns after the edge so nothing races the clock
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
    #10;
  endtask
  task automatic chk(logic [4:0] got, logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the planned run
  initial begin
    #400000;
    errors++;
    end_of_test;
  end
  // Straps, then lamp modes 00 and 01, then blinking
  initial begin
    k = $urandom(37);
    cyc(12);
    srst_i = 0;
    for (k = 0; k < 6; k++) begin
      {sa, sb} = k < 2 ? {2{k[0]}} : 2'($urandom);
      chip_rst_n_i = 0;
      cyc(8);
      chip_rst_n_i = 1;
      cyc(6);
      chk({speed_sel_o, adv_speed_o, autoneg_strap_o, status_lamp_a_oe_o, status_lamp_b_oe_o},
        {sb, sb, sa, 2'h3});
    end
    $display("strap test done");
    for (k = 0; k < 40; k++) begin
      // Software side keeps the mode field out of the reserved codes
      {lamp_mode_i, link_up_i, hundred_mbps_link_i} = 4'(k < 16 ? k : $urandom) & 4'h7;
      cyc(2);
      e = lamps(lamp_mode_i, link_up_i, hundred_mbps_link_i);
      chk(lamp, e);
    end
    $display("mode test done");
    link_up_i = 1;
    for (k = 0; k < 2; k++) begin
      lamp_mode_i = 2'(k);
      {tx_active_i, rx_active_i} = k ? 2'h2 : 2'h1;
      cyc(4);
      t = 0;
      repeat (16) begin
        p = lamp[!k];
        cyc(1);
        t += lamp[!k] != p;
      end
      chk(4'(t), 4'(16 / HALF));
      {tx_active_i, rx_active_i} = 2'h0;
      cyc(3);
      e = lamps(lamp_mode_i, 1'b1, hundred_mbps_link_i);
      chk(lamp, e);
    end
    $display("blink test done");
    end_of_test;
  end
endmodule // lsld_top_tb
